// [design/mcbs_pkg.sv]
// constants and types for the maintenance command buffer sequencer
package mcbs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [3:0] PTR_ZERO = 4'h0;
  localparam logic [3:0] PTR_ONES = 4'hf;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [3:0] BR_ALWAYS = 4'hf;
  localparam logic [3:0] BR_UCHK = 4'he;
  localparam logic [3:0] BR_TI = 4'hd;
  localparam logic [3:0] BR_UEXC = 4'h7;
  localparam logic [7:0] CMD_TEST = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ_FWD = 8'h02;
  localparam logic [7:0] CMD_NOP = 8'h03;
  localparam logic [7:0] CMD_SENSE = 8'h04;
  localparam logic [7:0] CMD_REWIND = 8'h07;
  localparam logic [7:0] CMD_DIAG_MODE = 8'h0b;
  localparam logic [7:0] CMD_READ_BWD = 8'h0c;
  localparam logic [7:0] CMD_TAPE_MARK = 8'h1f;
  localparam logic [7:0] CMD_START_CHAIN = 8'h4b;
  localparam logic [7:0] CMD_MODE_1600 = 8'hc3;
  localparam logic [7:0] CMD_MODE_800 = 8'hcb;
  localparam logic [7:0] CMD_HANG = 8'hff;
  localparam int unsigned WAIT_P1_MS = 600;
  localparam int unsigned WAIT_P2_MS = 200;
  localparam int unsigned WAIT_P3_MS = 150;
  localparam int unsigned WAIT_P4_MS = 13;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WAIT_P1_CYC = WAIT_P1_MS * CYC_PER_MS;
  localparam int unsigned WAIT_P2_CYC = WAIT_P2_MS * CYC_PER_MS;
  localparam int unsigned WAIT_P3_CYC = WAIT_P3_MS * CYC_PER_MS;
  localparam int unsigned WAIT_P4_CYC = WAIT_P4_MS * CYC_PER_MS;
  typedef struct packed {
    logic stop_flag_bit;
    logic address_flag_bit;
    logic branch_flag_bit;
    logic parity;
    logic [7:0] payload;
  } mcbs_entry_t;
  typedef struct packed {
    logic unit_check;
    logic unit_exception;
    logic tape_indicate_flag;
    logic nrzi_status;
  } mcbs_cond_t;
  typedef enum logic [1:0] {
    MCBS_OP_NONE,
    MCBS_OP_WRITE,
    MCBS_OP_READ_FWD,
    MCBS_OP_READ_BWD
  } mcbs_op_t;
endpackage

// [design/mcbs_fifo.sv]
// parameterised valid/ready fifo for forwarded data bytes
`timescale 1ns/10ps
`default_nettype none
module mcbs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [design/mcbs_sequencer.sv]
// maintenance command buffer sequencer top
`timescale 1ns/10ps
`default_nettype none
module mcbs_sequencer
  import mcbs_pkg::*;
#(
  parameter int unsigned WAIT_P1 = mcbs_pkg::WAIT_P1_CYC,
  parameter int unsigned WAIT_P2 = mcbs_pkg::WAIT_P2_CYC,
  parameter int unsigned WAIT_P3 = mcbs_pkg::WAIT_P3_CYC,
  parameter int unsigned WAIT_P4 = mcbs_pkg::WAIT_P4_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // buffer loading and setup
  input wire logic load_we,
  input wire logic [3:0] load_addr,
  input wire mcbs_pkg::mcbs_entry_t load_entry,
  input wire logic [3:0] command_upper_limit,
  input wire logic [3:0] data_lower_limit,
  input wire logic [3:0] cmd_ptr_preset,
  input wire logic cmd_ptr_set,
  input wire logic [11:0] byte_count_preset,
  input wire logic [1:0] priority_sel,
  input wire logic stop_on_miscompare_switch,
  // operator controls
  input wire logic start,
  input wire logic stop_loop_trigger,
  // unit status
  input wire mcbs_pkg::mcbs_cond_t cond,
  input wire logic cmd_done,
  // data path
  input wire logic [7:0] io_holding_in,
  input wire logic io_holding_valid,
  output logic data_valid,
  input wire logic data_ready,
  output logic [7:0] data_out,
  // command issue
  output logic cmd_valid,
  output logic [7:0] command_reg,
  output logic [7:0] tape_unit_addr,
  output logic parity_error,
  // host channel
  input wire logic host_select,
  output logic host_busy_sm,
  output logic request_in,
  input wire logic host_poll,
  output logic cu_end,
  output logic host_break_ok,
  // status
  output logic running,
  output logic op_complete,
  output logic miscompare,
  output mcbs_pkg::mcbs_entry_t buffer_data_reg,
  output logic [7:0] io_holding_reg,
  output logic [11:0] byte_down_counter,
  output logic [3:0] cmd_ptr,
  output logic [3:0] data_pointer
);
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR0, S_FETCH, S_DECODE, S_EXEC, S_DATA, S_HANG, S_CUE, S_PWAIT
  } mcbs_state_t;
  mcbs_state_t state_q;
  mcbs_entry_t mem_q [DEPTH];
  mcbs_op_t op_q;
  logic chain_q;
  logic hd_latch_q;
  logic pend_q;
  logic stop_pend_q;
  logic force_next_q;
  logic [31:0] wait_q;
  logic [7:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fetch_go;
  logic cmp_mode;
  mcbs_entry_t fetched;
  logic blocked;
  logic cmp_pend_q;
  logic mis_now;

  function automatic logic br_taken(input logic [3:0] code, input mcbs_cond_t c);
    case (code)
      BR_ALWAYS: br_taken = 1'b1;
      BR_UCHK: br_taken = c.unit_check;
      BR_TI: br_taken = c.tape_indicate_flag;
      BR_UEXC: br_taken = c.unit_exception;
      default: br_taken = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] cmd_next(input logic [3:0] p, input logic [3:0] ub);
    cmd_next = (p == ub) ? PTR_ZERO : p + 4'h1;
  endfunction

  function automatic logic is_mode(input logic [7:0] c);
    is_mode = (c == CMD_MODE_1600) || (c == CMD_MODE_800) || (c == CMD_DIAG_MODE);
  endfunction

  // buffer storage, 12-bit entries
  always_ff @(posedge clk) begin
    if (ce && load_we) begin
      mem_q[load_addr] <= load_entry;
    end
  end

  assign fetched = mem_q[cmd_ptr];
  assign cmp_mode = (op_q == MCBS_OP_READ_FWD) && stop_on_miscompare_switch;
  // break-in blocked by chain or low density in nrzi
  assign blocked = chain_q || (!hd_latch_q && cond.nrzi_status);
  assign fetch_go = ce && (state_q == S_DATA) && !miscompare && !mis_now && (byte_down_counter != CNT_ZERO)
    && ((op_q == MCBS_OP_WRITE) ? fifo_in_ready : io_holding_valid);
  assign running = state_q != S_IDLE;
  // only between commands
  assign host_break_ok = (state_q == S_IDLE || state_q == S_PWAIT) && !blocked;
  assign host_busy_sm = host_select && running && !host_break_ok;

  // sequencer state machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      cmd_ptr <= PTR_ZERO;
      op_q <= MCBS_OP_NONE;
      cmd_valid <= 1'b0;
      command_reg <= 8'h00;
      tape_unit_addr <= 8'h00;
      chain_q <= 1'b0;
      hd_latch_q <= 1'b0;
      stop_pend_q <= 1'b0;
      force_next_q <= 1'b0;
      wait_q <= '0;
      cu_end <= 1'b0;
      op_complete <= 1'b0;
      parity_error <= 1'b0;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      cu_end <= 1'b0;
      op_complete <= 1'b0;
      if (cmd_ptr_set && state_q == S_IDLE) begin
        cmd_ptr <= cmd_ptr_preset;
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_ADDR0;
          end
        end
        S_ADDR0: begin
          if (mem_q[0].address_flag_bit) begin
            tape_unit_addr <= mem_q[0].payload;
          end
          state_q <= S_FETCH;
        end
        S_FETCH: begin
          cmd_ptr <= cmd_next(cmd_ptr, command_upper_limit);
          parity_error <= ~^{fetched.parity, fetched.payload};
          state_q <= S_DECODE;
        end
        S_DECODE: begin
          stop_pend_q <= buffer_data_reg.stop_flag_bit;
          if (buffer_data_reg.branch_flag_bit) begin
            if (br_taken(buffer_data_reg.payload[7:4], cond)) begin
              cmd_ptr <= buffer_data_reg.payload[3:0];
            end
            state_q <= buffer_data_reg.stop_flag_bit ? S_IDLE : S_FETCH;
          end else if (buffer_data_reg.address_flag_bit) begin
            tape_unit_addr <= buffer_data_reg.payload;
            state_q <= buffer_data_reg.stop_flag_bit ? S_IDLE : S_FETCH;
          end else if (buffer_data_reg.payload == CMD_HANG) begin
            command_reg <= buffer_data_reg.payload;
            cmd_valid <= 1'b1;
            cmd_ptr <= PTR_ZERO;
            state_q <= S_HANG;
          end else begin
            command_reg <= buffer_data_reg.payload;
            cmd_valid <= 1'b1;
            case (buffer_data_reg.payload)
              CMD_WRITE: op_q <= MCBS_OP_WRITE;
              CMD_READ_FWD: op_q <= MCBS_OP_READ_FWD;
              CMD_READ_BWD: op_q <= MCBS_OP_READ_BWD;
              default: op_q <= MCBS_OP_NONE;
            endcase
            if (buffer_data_reg.payload == CMD_START_CHAIN) begin
              chain_q <= 1'b1;
            end
            if (buffer_data_reg.payload == CMD_TEST) begin
              chain_q <= 1'b0;
            end
            if (buffer_data_reg.payload == CMD_MODE_800) begin
              hd_latch_q <= 1'b0;
            end
            if (buffer_data_reg.payload == CMD_MODE_1600) begin
              hd_latch_q <= 1'b1;
            end
            force_next_q <= is_mode(buffer_data_reg.payload) || buffer_data_reg.payload == CMD_NOP;
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (op_q != MCBS_OP_NONE) begin
            state_q <= S_DATA;
          end else if (cmd_done) begin
            state_q <= S_CUE;
          end
        end
        S_DATA: begin
          if (byte_down_counter == CNT_ZERO || cmd_done) begin
            op_complete <= 1'b1;
            op_q <= MCBS_OP_NONE;
            state_q <= S_CUE;
          end
        end
        S_HANG: begin
          if (stop_loop_trigger) begin
            state_q <= S_IDLE;
          end
        end
        S_CUE: begin
          if (stop_pend_q) begin
            state_q <= S_IDLE;
          end else if (force_next_q) begin
            force_next_q <= 1'b0;
            state_q <= S_ADDR0;
          end else if (pend_q && !blocked) begin
            if (host_poll) begin
              cu_end <= 1'b1;
              case (priority_sel)
                2'h0: wait_q <= WAIT_P1;
                2'h1: wait_q <= WAIT_P2;
                2'h2: wait_q <= WAIT_P3;
                default: wait_q <= WAIT_P4;
              endcase
              state_q <= S_PWAIT;
            end
          end else begin
            state_q <= S_ADDR0;
          end
        end
        S_PWAIT: begin
          if (host_select) begin
            state_q <= S_IDLE;
          end else if (wait_q <= 32'd1) begin
            state_q <= S_ADDR0;
          end else begin
            wait_q <= wait_q - 32'd1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // remembered host request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      if (host_busy_sm) begin
        pend_q <= 1'b1;
      end else if (cu_end) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign request_in = pend_q && state_q == S_CUE && !stop_pend_q && !force_next_q && !blocked;

  // buffer data register, fetch and freeze
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buffer_data_reg <= '0;
      io_holding_reg <= 8'h00;
    end else if (ce) begin
      if (state_q == S_FETCH) begin
        buffer_data_reg <= fetched;
      end else if (fetch_go) begin
        buffer_data_reg <= mem_q[data_pointer];
      end
      if (fetch_go && op_q != MCBS_OP_WRITE) begin
        io_holding_reg <= io_holding_in;
      end
    end
  end

  // compare of the last fetched byte; freeze on mismatch
  assign mis_now = cmp_pend_q && (buffer_data_reg.payload != io_holding_reg);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_pend_q <= 1'b0;
      miscompare <= 1'b0;
    end else if (ce) begin
      cmp_pend_q <= fetch_go && cmp_mode;
      if (state_q == S_IDLE && start) begin
        miscompare <= 1'b0;
      end else if (mis_now) begin
        miscompare <= 1'b1;
      end
    end
  end

  // data pointer and byte counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_pointer <= PTR_ZERO;
      byte_down_counter <= CNT_ZERO;
    end else if (ce) begin
      if (state_q == S_DECODE) begin
        data_pointer <= (buffer_data_reg.payload == CMD_READ_BWD) ? PTR_ONES : data_lower_limit;
        byte_down_counter <= byte_count_preset;
      end else if (fetch_go) begin
        byte_down_counter <= byte_down_counter - 12'h001;
        if (op_q == MCBS_OP_READ_BWD) begin
          data_pointer <= (data_pointer == data_lower_limit) ? PTR_ONES : data_pointer - 4'h1;
        end else begin
          data_pointer <= (data_pointer == PTR_ONES) ? data_lower_limit : data_pointer + 4'h1;
        end
      end
    end
  end

  // forward path buffered toward data path
  assign fifo_in = mem_q[data_pointer].payload;
  assign fifo_in_valid = fetch_go && op_q == MCBS_OP_WRITE && !cmp_mode;
  mcbs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(data_valid),
    .out_ready(data_ready),
    .out_data(data_out)
  );

  property p_wrap;
    @(posedge clk) disable iff (!arst_n)
    (ce && state_q == S_FETCH && cmd_ptr == command_upper_limit) |=> cmd_ptr == PTR_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("command pointer did not wrap");
  property p_hang;
    @(posedge clk) disable iff (!arst_n)
    (ce && state_q == S_HANG && !stop_loop_trigger) |=> state_q == S_HANG && cmd_ptr == PTR_ZERO;
  endproperty
  a_hang: assert property (p_hang) else $error("hang left early");
  property p_count;
    @(posedge clk) disable iff (!arst_n)
    fetch_go |=> byte_down_counter == $past(byte_down_counter) - 12'h001;
  endproperty
  a_count: assert property (p_count) else $error("byte counter not decremented");
  property p_zero;
    @(posedge clk) disable iff (!arst_n)
    (ce && state_q == S_DATA && byte_down_counter == CNT_ZERO) |-> !fetch_go ##1 (op_complete && state_q == S_CUE);
  endproperty
  a_zero: assert property (p_zero) else $error("zero count did not end the operation");
  property p_freeze;
    @(posedge clk) disable iff (!arst_n)
    (miscompare && !(state_q == S_IDLE && start)) |=> $stable(buffer_data_reg) && $stable(io_holding_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("registers changed after miscompare");
  property p_fwd;
    @(posedge clk) disable iff (!arst_n)
    (fetch_go && op_q == MCBS_OP_WRITE && data_pointer == PTR_ONES) |=> data_pointer == data_lower_limit;
  endproperty
  a_fwd: assert property (p_fwd) else $error("data pointer reload wrong");
  property p_bwd;
    @(posedge clk) disable iff (!arst_n)
    (fetch_go && op_q == MCBS_OP_READ_BWD && data_pointer == data_lower_limit) |=> data_pointer == PTR_ONES;
  endproperty
  a_bwd: assert property (p_bwd) else $error("backward reload wrong");
  property p_chain;
    @(posedge clk) disable iff (!arst_n)
    chain_q |-> !host_break_ok;
  endproperty
  a_chain: assert property (p_chain) else $error("break-in during chain");
  property p_cmd;
    @(posedge clk) disable iff (!arst_n)
    cmd_valid |-> !$past(buffer_data_reg.address_flag_bit) && !$past(buffer_data_reg.branch_flag_bit);
  endproperty
  a_cmd: assert property (p_cmd) else $error("flagged entry issued as command");
endmodule
`default_nettype wire

// [verification/mcbs_partner.sv]
// far-side model: microprogram command completion and data path sink
`timescale 1ns/10ps
`default_nettype none
module mcbs_partner (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // command side
  input wire logic cmd_valid,
  input wire logic [7:0] command_reg,
  input wire logic [4:0] done_lat,
  output logic cmd_done,
  // data side
  input wire logic stall,
  output logic data_ready
);
  import mcbs_pkg::*;
  logic [4:0] cnt_q;
  logic busy_q;
  // data path takes a byte each cycle unless stalled
  assign data_ready = !stall;
  // data commands end on byte count, hang never ends by itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= busy_q && (cnt_q == done_lat);
      if (cmd_valid && !(command_reg inside {CMD_WRITE, CMD_READ_FWD, CMD_READ_BWD, CMD_HANG})) begin
        busy_q <= 1'b1;
        cnt_q <= 5'h00;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == done_lat) busy_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/mcbs_tb_top.sv]
// self-checking bench for the command buffer sequencer
`timescale 1ns/10ps
`default_nettype none
module maintenance_command_buffer_sequencer_tb_top;
  import mcbs_pkg::*;
  localparam int WP4 = 12;
  logic clk = 0, arst_n = 0, ce = 1, load_we = 0, cmd_ptr_set = 0, cmd_done, start = 0;
  logic stop_loop_trigger = 0, stop_on_miscompare_switch = 0, io_holding_valid = 0, host_select = 0;
  logic host_poll = 0, stall = 0, data_valid, data_ready, cmd_valid, parity_error, host_busy_sm;
  logic request_in, cu_end, host_break_ok, running, op_complete, miscompare;
  logic [3:0] load_addr = 0, command_upper_limit = 0, data_lower_limit = 0, cmd_ptr_preset = 0;
  logic [3:0] cmd_ptr, data_pointer;
  logic [11:0] byte_count_preset = 0, byte_down_counter;
  logic [1:0] priority_sel = 2'h3;
  logic [7:0] io_holding_in = 0, data_out, command_reg, tape_unit_addr, io_holding_reg, ad;
  logic [4:0] done_lat = 5'h02;
  mcbs_entry_t load_entry = '0, buffer_data_reg;
  mcbs_cond_t cond = '0;
  logic [11:0] cq[$], dq[$];
  logic [15:0] lf = 16'h7d59; // seed 32089
  logic [3:0] codes[4] = '{4'hf, 4'he, 4'hd, 4'h7};
  logic t;
  int err_total = 0, compares = 0, cycles = 0, i, k, n;

  mcbs_sequencer #(.WAIT_P1(40), .WAIT_P2(30), .WAIT_P3(20), .WAIT_P4(WP4)) uut (.clk, .arst_n, .ce,
    .load_we, .load_addr, .load_entry, .command_upper_limit, .data_lower_limit, .cmd_ptr_preset,
    .cmd_ptr_set, .byte_count_preset, .priority_sel, .stop_on_miscompare_switch, .start,
    .stop_loop_trigger, .cond, .cmd_done, .io_holding_in, .io_holding_valid, .data_valid, .data_ready,
    .data_out, .cmd_valid, .command_reg, .tape_unit_addr, .parity_error, .host_select, .host_busy_sm,
    .request_in, .host_poll, .cu_end, .host_break_ok, .running, .op_complete, .miscompare,
    .buffer_data_reg, .io_holding_reg, .byte_down_counter, .cmd_ptr, .data_pointer);
  mcbs_partner far_end (.clk, .arst_n, .cmd_valid, .command_reg, .done_lat, .cmd_done, .stall, .data_ready);

  always #10 clk = ~clk;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // entry with odd parity over the payload
  function automatic mcbs_entry_t ent(input logic [2:0] f, input logic [7:0] p);
    ent = {f, ~^p, p};
  endfunction
  task automatic cyc(input int m);
    repeat (m) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input mcbs_entry_t e);
    load_we = 1;
    load_addr = a;
    load_entry = e;
    cyc(1);
    load_we = 0;
    cyc(1);
  endtask
  task automatic rst();
    arst_n = 0;
    cq.delete();
    dq.delete();
    cyc(2);
    arst_n = 1;
  endtask
  task automatic go();
    start = 1;
    cyc(1);
    start = 0;
  endtask
  task automatic wait_idle(input string s);
    for (k = 0; k < 400 && (running !== 1'b0 || data_valid !== 1'b0); k++) cyc(1);
    chk(running, 0);
    chk(cq.size() + dq.size(), 0);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // result watcher: each command issued or byte forwarded takes the oldest note
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) chk(command_reg, cq.size() ? cq.pop_front() : 'x);
    if (data_valid === 1'b1 && data_ready === 1'b1) chk(data_out, dq.size() ? dq.pop_front() : 'x);
    if (op_complete === 1'b1) chk(byte_down_counter, 0);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    rst();
    // write with fifo fill under stall, branch skip, stop
    wr(0, ent(3'b010, 8'h80));
    wr(1, ent(0, CMD_WRITE));
    wr(2, ent(3'b001, {BR_ALWAYS, 4'h4}));
    wr(3, ent(0, CMD_SENSE));
    wr(4, ent(3'b100, CMD_TEST));
    wr(14, ent(0, lf[7:0]));
    wr(15, ent(0, lf[15:8]));
    command_upper_limit = 4;
    data_lower_limit = 14;
    byte_count_preset = 12'h028;
    cq = '{CMD_WRITE, CMD_TEST};
    for (i = 0; i < 40; i++) dq.push_back(i[0] ? lf[15:8] : lf[7:0]);
    stall = 1;
    go();
    cyc(80);
    chk(byte_down_counter, 12'h008);
    stall = 0;
    wait_idle("write");
    chk(tape_unit_addr, 8'h80);
    chk(byte_down_counter, byte_count_preset);
    // every branch code with its condition random
    command_upper_limit = 3;
    for (i = 0; i < 8; i++) begin
      lf = nxt(lf);
      t = lf[0] ^ i[2];
      ad = lf[8:1];
      rst();
      cond = {codes[i % 4] == 4'he && t, codes[i % 4] == 4'h7 && t, codes[i % 4] == 4'hd && t, 1'b0};
      wr(0, ent(3'b010, ad));
      wr(1, ent(3'b001, {codes[i % 4], 4'h3}));
      wr(2, ent(3'b100, CMD_SENSE));
      wr(3, ent(3'b100, CMD_REWIND));
      cq.push_back((codes[i % 4] == 4'hf || t) ? CMD_REWIND : CMD_SENSE);
      go();
      wait_idle("branch");
      chk(tape_unit_addr, ad);
    end
    cond = '0;
    // read forward compare, mismatch freezes, reset in mid-run
    rst();
    wr(1, ent(3'b100, CMD_READ_FWD));
    wr(14, ent(0, 8'haa));
    wr(15, ent(0, 8'h55));
    byte_count_preset = 3;
    stop_on_miscompare_switch = 1;
    cq = '{CMD_READ_FWD};
    go();
    cyc(8);
    io_holding_valid = 1;
    io_holding_in = 8'haa;
    cyc(1);
    io_holding_in = 8'h5a;
    cyc(1);
    io_holding_in = 8'hc3;
    cyc(1);
    io_holding_valid = 0;
    cyc(6);
    chk(miscompare, 1);
    chk(running, 1);
    chk(byte_down_counter, 12'h001);
    chk(data_pointer, data_lower_limit);
    chk(data_valid, 0);
    chk(io_holding_reg, 8'h5a);
    chk(buffer_data_reg.payload, 8'h55);
    chk(cq.size(), 0);
    $display("test compare done");
    stop_on_miscompare_switch = 0;
    // host request during a slow command, busy, poll, priority wait
    rst();
    wr(0, ent(3'b010, 8'h80));
    wr(1, ent(0, CMD_SENSE));
    wr(2, ent(3'b100, CMD_REWIND));
    command_upper_limit = 2;
    done_lat = 5'h0a;
    cq = '{CMD_SENSE, CMD_REWIND};
    go();
    cyc(6);
    host_select = 1;
    cyc(1);
    chk(host_busy_sm, 1);
    chk(host_break_ok, 0);
    host_select = 0;
    for (k = 0; k < 40 && request_in !== 1'b1; k++) cyc(1);
    chk(request_in, 1);
    host_poll = 1;
    for (k = 0; k < 10 && cu_end !== 1'b1; k++) cyc(1);
    chk(cu_end, 1);
    host_poll = 0;
    for (n = 0; n < 60 && cmd_valid !== 1'b1; n++) cyc(1);
    chk(n >= WP4 && n < WP4 + 12, 1);
    wait_idle("host");
    done_lat = 5'h02;
    // chained commands then hang until the stop-loop trigger
    rst();
    cond.nrzi_status = 1;
    wr(0, ent(3'b010, 8'h80));
    wr(1, ent(0, CMD_START_CHAIN));
    wr(2, ent(0, CMD_MODE_800) ^ 12'h100); // bad parity
    wr(3, ent(0, CMD_HANG));
    command_upper_limit = 3;
    cq = '{CMD_START_CHAIN, CMD_MODE_800, CMD_HANG};
    go();
    cyc(12);
    chk(host_break_ok, 0);
    cyc(4);
    chk(parity_error, 1);
    cyc(30);
    chk(running, 1);
    chk(cmd_ptr, 0);
    stop_loop_trigger = 1;
    wait_idle("hang");
    chk(host_break_ok, 0);
    stop_loop_trigger = 0;
    // read backward steps down and reloads all ones past the lower limit
    rst();
    wr(1, ent(3'b100, CMD_READ_BWD));
    byte_count_preset = 2;
    io_holding_valid = 1;
    cq = '{CMD_READ_BWD};
    go();
    wait_idle("read backward");
    chk(data_pointer, PTR_ONES);
    io_holding_valid = 0;
    end_of_test();
  end
endmodule
`default_nettype wire
